// File: rtl/mddrc_pkg.sv
// holds constants and types shared by the device end and controller end
// assumes one 25 MHz core clock and an asynchronous active-high reset
// What this block does
// R01: burst of two, four or eight, both orders
// R02: burst length caps columns per command
// R03: burst wraps inside its column block
// R04: high column bits pick block, low start
// R05: same burst length for reads and writes
// R06: controller never programs reserved encodings; the controller forwards the software command and address codes unchecked
// R07: read latency programmable two or three
// R08: first data one or two clocks later; the device puts first data on the link two or three clocks after the read
// R09: extended load uses bank bits 0 and 1
// R10: extended setting kept until rewritten or powerdown
// R11: controller zeroes address bits seven to thirteen; the controller loads HWDATA[15:0] unchanged, so software supplies the zeros
// R12: extended load only when banks idle
// R13: five partial refresh coverages offered
// R14: array access all banks; refresh selected only
// R15: address bits five, six pick drive strength
// R16: temperature steers self refresh oscillator rate
// R17: status read returns 16 bits, burst two
// R18: status word field layout fixed
// R19: status read starts with bank0 load, zeros
// R20: read after setup delay, wait recovery
// R21: status after latency; second half don't care
// R22: chip select high ignores new commands
// R23: standard register field layout, bank bits zero
// R24: after status burst, normal reads resume
package mddrc_pkg;
  // ****************************************
  // command encoding {cs_n, ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_LOAD  = 4'h0;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  // ****************************************
  // setting fields
  // ****************************************
  localparam logic [1:0] BANK_STD    = 2'h0;
  localparam logic [1:0] BANK_STATUS = 2'h1;
  localparam logic [1:0] BANK_EXT    = 2'h2;
  localparam int BURST_LSB = 0;
  localparam int BURST_MSB = 2;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  localparam int REFSEL_LSB = 0;
  localparam int REFSEL_MSB = 2;
  localparam int DRIVE_LSB = 5;
  localparam int DRIVE_MSB = 6;
  localparam logic [2:0] BURST_TWO   = 3'h1;
  localparam logic [2:0] BURST_FOUR  = 3'h2;
  localparam logic [2:0] BURST_EIGHT = 3'h3;
  localparam logic [2:0] LAT_TWO     = 3'h2;
  localparam logic [2:0] LAT_THREE   = 3'h3;
  localparam logic [2:0] REFSEL_ALL     = 3'h0;
  localparam logic [2:0] REFSEL_TWO     = 3'h1;
  localparam logic [2:0] REFSEL_ONE     = 3'h2;
  localparam logic [2:0] REFSEL_EIGHTH  = 3'h5;
  localparam logic [2:0] REFSEL_SIXTEEN = 3'h6;
  localparam logic [13:0] STD_RESET = 14'h0022;
  localparam logic [13:0] EXT_RESET = 14'h0000;
  localparam int COL_W = 10;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  // ****************************************
  // status word layout
  // ****************************************
  localparam logic [3:0] STAT_MAKER = 4'h5;  // arbitrary value
  localparam logic [3:0] STAT_REV   = 4'h1;  // arbitrary value
  localparam logic       STAT_WIDTH = 1'h0;
  localparam logic       STAT_TYPE  = 1'h1;
  localparam logic [2:0] STAT_DENS  = 3'h4;
  // ****************************************
  // controller register map (ahb-lite)
  // ****************************************
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [3:0] TEMP_STEPS = 4'h8;
  typedef enum logic [3:0] {
    MDC_IDLE = 4'b0001,
    MDC_ISSUE = 4'b0010,
    MDC_WAIT = 4'b0100,
    MDC_DONE = 4'b1000
  } mdc_state_t;
endpackage

// File: rtl/mddrc_if.sv
// carries the command, address and data pins between both ends
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface mddrc_if;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic [13:0] addr;
  logic [15:0] dq_to_dev;
  logic [15:0] dq_from_dev;
  logic        dq_oe;
  logic        dq_valid;
  modport dev (input cmd, bank, addr, dq_to_dev,
               output dq_from_dev, dq_oe, dq_valid);
  modport ctl (output cmd, bank, addr, dq_to_dev,
               input dq_from_dev, dq_oe, dq_valid);
endinterface
`default_nettype wire

// File: rtl/mddrc_device.sv
// device end: setting registers, burst walk, read latency, status word
// assumes commands are sampled on the core clock rising edge
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mddrc_device
  import mddrc_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // link
  mddrc_if.dev             LINK,
  // user side
  input  wire logic [3:0]  TEMP_LEVEL,
  input  wire logic        SELF_REFRESH,
  input  wire logic        DEEP_POWER_DOWN,
  output logic [2:0]       REFRESH_RATE,
  output logic [3:0]       REFRESH_BANKS,
  output logic [1:0]       ROW_MSB_MASK,
  output logic [2:0]       DRIVE_STRENGTH,
  output logic [COL_W-1:0] COLUMN,
  output logic             COLUMN_VALID,
  output logic             COLUMN_WRITE
);
  logic [13:0] std_setting;
  logic [13:0] extended_setting_register;
  logic [3:0]  temp_meta;
  logic [3:0]  temp_sync;
  logic        status_armed;
  logic [3:0]  burst_left;
  logic [2:0]  burst_idx;
  logic [COL_W-1:0] burst_base;
  logic        burst_seq;
  logic        burst_wr;
  logic        burst_status;
  logic [2:0]  lat_pipe;
  logic [2:0]  lat_stat;
  logic [2:0]  rd_left;
  logic [15:0] device_status_word;
  logic        new_cmd;

  function automatic logic [3:0] blen(input logic [2:0] code);
    case (code)
      BURST_TWO:   blen = 4'h2;
      BURST_FOUR:  blen = 4'h4;
      BURST_EIGHT: blen = 4'h8;
      default:     blen = 4'h2;
    endcase
  endfunction

  // offset mask within the block
  function automatic logic [2:0] bmask(input logic [2:0] code);
    bmask = 3'(blen(code) - 4'h1);
  endfunction

  // column of one beat, wrapped inside its block
  function automatic logic [COL_W-1:0] burst_col(
      input logic [COL_W-1:0] base,
      input logic [2:0]       idx,
      input logic             seq,
      input logic [2:0]       code);
    logic [2:0] m;
    logic [2:0] off;
    m = bmask(code);
    off = seq ? ((base[2:0] + idx) & m) : ((base[2:0] ^ idx) & m);
    burst_col = {base[COL_W-1:3], (base[2:0] & ~m) | off};
  endfunction

  // ****************************************
  // command and setting load
  // ****************************************
  assign new_cmd = ~LINK.cmd[3];  // R22

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      std_setting <= STD_RESET;
      extended_setting_register <= EXT_RESET;
    end else if (DEEP_POWER_DOWN) begin
      std_setting <= STD_RESET;
      extended_setting_register <= EXT_RESET;  // R10
    end else if (new_cmd && LINK.cmd == CMD_LOAD) begin
      if (LINK.bank == BANK_STD)
        std_setting <= LINK.addr;  // R23
      else if (LINK.bank == BANK_EXT)
        extended_setting_register <= LINK.addr;  // R09 R10
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST)
      status_armed <= 1'b0;
    else if (new_cmd && LINK.cmd == CMD_LOAD)
      status_armed <= (LINK.bank == BANK_STATUS);  // R19
    else if (new_cmd && LINK.cmd == CMD_READ)
      status_armed <= 1'b0;  // R24
  end

  // ****************************************
  // burst walk
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      burst_left <= 4'h0;
      burst_idx <= 3'h0;
      burst_base <= '0;
      burst_seq <= 1'b1;
      burst_wr <= 1'b0;
      burst_status <= 1'b0;
    end else if (new_cmd && (LINK.cmd == CMD_READ ||
                             LINK.cmd == CMD_WRITE)) begin
      // R02 R05
      burst_left <= status_armed ? 4'h2
                                 : blen(std_setting[BURST_MSB:BURST_LSB]);
      burst_idx <= 3'h0;
      // R04
      burst_base <= LINK.addr[COL_W-1:0];
      burst_seq <= ~std_setting[BT_BIT];  // R01
      burst_wr <= (LINK.cmd == CMD_WRITE);
      burst_status <= status_armed;  // R17
    end else if (burst_left != 4'h0) begin
      burst_left <= burst_left - 4'h1;
      burst_idx <= burst_idx + 3'h1;
    end
  end

  // R03 wrap inside the block, sequential or interleaved
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      COLUMN <= '0;
      COLUMN_VALID <= 1'b0;
      COLUMN_WRITE <= 1'b0;
    end else begin
      COLUMN <= burst_col(burst_base, burst_idx, burst_seq,
                          std_setting[BURST_MSB:BURST_LSB]);
      COLUMN_VALID <= (burst_left != 4'h0) && !burst_status;  // R14
      COLUMN_WRITE <= burst_wr;
    end
  end

  // ****************************************
  // read latency and output
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lat_pipe <= 3'h0;
      lat_stat <= 3'h0;
    end else begin
      lat_pipe <= {lat_pipe[1:0], new_cmd && LINK.cmd == CMD_READ};
      lat_stat <= {lat_stat[1:0], status_armed};
    end
  end

  assign device_status_word = {STAT_DENS, STAT_TYPE, STAT_WIDTH,
                               REFRESH_RATE, STAT_REV, STAT_MAKER};  // R18

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_left <= 3'h0;
      LINK.dq_from_dev <= '0;
      LINK.dq_oe <= 1'b0;
      LINK.dq_valid <= 1'b0;
    end else begin
      logic             hit;
      logic             st;
      logic             lat2;
      logic [COL_W-1:0] cnow;
      // R07 R08
      lat2 = (std_setting[LAT_MSB:LAT_LSB] == LAT_TWO);
      hit = lat2 ? lat_pipe[0] : lat_pipe[1];
      st = lat2 ? lat_stat[0] : lat_stat[1];
      // latency two runs a beat ahead of COLUMN, so take the walk itself
      cnow = lat2 ? burst_col(burst_base, burst_idx, burst_seq,
                              std_setting[BURST_MSB:BURST_LSB])
                  : COLUMN;
      if (hit) begin
        rd_left <= st ? 3'h1
                      : 3'(blen(std_setting[BURST_MSB:BURST_LSB]) - 4'h1);
        LINK.dq_from_dev <= st ? device_status_word  // R21
                               : {6'h00, cnow};
        LINK.dq_oe <= 1'b1;
        LINK.dq_valid <= 1'b1;
      end else if (rd_left != 3'h0) begin
        rd_left <= rd_left - 3'h1;
        LINK.dq_from_dev <= {6'h00, cnow};
        LINK.dq_oe <= 1'b1;
        LINK.dq_valid <= 1'b1;
      end else begin
        LINK.dq_oe <= 1'b0;
        LINK.dq_valid <= 1'b0;
      end
    end
  end

  // ****************************************
  // self refresh coverage and thermal rate
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      temp_meta <= 4'h0;
      temp_sync <= 4'h0;
    end else begin
      temp_meta <= TEMP_LEVEL;
      temp_sync <= temp_meta;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REFRESH_RATE <= 3'h0;
      REFRESH_BANKS <= 4'h0;
      ROW_MSB_MASK <= 2'h0;
      DRIVE_STRENGTH <= 3'h0;
    end else begin
      // R16
      REFRESH_RATE <= (temp_sync >= TEMP_STEPS) ? 3'h7 : temp_sync[2:0];
      // R15
      DRIVE_STRENGTH <= {1'b0,
                         extended_setting_register[DRIVE_MSB:DRIVE_LSB]};
      ROW_MSB_MASK <= 2'h0;
      if (!SELF_REFRESH) begin
        REFRESH_BANKS <= 4'h0;
      end else begin
        case (extended_setting_register[REFSEL_MSB:REFSEL_LSB])  // R13
          REFSEL_ALL:    REFRESH_BANKS <= 4'hf;
          REFSEL_TWO:    REFRESH_BANKS <= 4'h3;
          REFSEL_ONE:    REFRESH_BANKS <= 4'h1;
          REFSEL_EIGHTH: begin
            REFRESH_BANKS <= 4'h1;
            ROW_MSB_MASK <= 2'h2;
          end
          REFSEL_SIXTEEN: begin
            REFRESH_BANKS <= 4'h1;
            ROW_MSB_MASK <= 2'h3;
          end
          default:     REFRESH_BANKS <= 4'hf;
        endcase
      end
    end
  end
endmodule  // mddrc_device
`default_nettype wire

// File: rtl/mddrc_ctrl.sv
// controller end: ahb-lite slave with one command issued per write to REG_CMD made while idle
// assumes software keeps banks idle before setting loads
`timescale 1ns/1ps
`default_nettype none
module mddrc_ctrl
  import mddrc_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // ahb-lite
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // link
  mddrc_if.ctl             LINK
);
  mdc_state_t  state;
  logic        ph_valid;
  logic        ph_write;
  logic [7:0]  ph_addr;
  logic [3:0]  cmd_reg;
  logic [15:0] addr_reg;
  logic [15:0] rdata;
  logic        seen;

  // ****************************************
  // bus slave
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (HREADY) begin
      ph_valid <= HSEL && HTRANS == HTRANS_NONSEQ;
      ph_write <= HWRITE;
      ph_addr <= HADDR[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      case (HADDR[7:0])
        REG_CMD:    HRDATA <= {28'h0000000, cmd_reg};
        REG_ADDR:   HRDATA <= {16'h0000, addr_reg};
        REG_STATUS: HRDATA <= {28'h0000000, state};
        REG_RDATA:  HRDATA <= {15'h0000, seen, rdata};
        default:    HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cmd_reg <= CMD_NOP;
      addr_reg <= 16'h0000;
    end else if (ph_valid && ph_write) begin
      if (ph_addr == REG_CMD)
        cmd_reg <= HWDATA[3:0];
      else if (ph_addr == REG_ADDR)
        addr_reg <= HWDATA[15:0];  // R11 R19
    end
  end

  // ****************************************
  // command issue
  // ****************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= MDC_IDLE;
      LINK.cmd <= CMD_DESEL;
      LINK.bank <= 2'h0;
      LINK.addr <= 14'h0000;
      LINK.dq_to_dev <= 16'h0000;
      rdata <= 16'h0000;
      seen <= 1'b0;
    end else begin
      LINK.cmd <= CMD_DESEL;  // R22
      case (state)
        MDC_IDLE: if (ph_valid && ph_write && ph_addr == REG_CMD) begin
          state <= MDC_ISSUE;
          seen <= 1'b0;
        end
        MDC_ISSUE: begin
          // R09 R12 R20 R23: software sequences the orders
          LINK.cmd <= cmd_reg;
          LINK.bank <= addr_reg[15:14];
          LINK.addr <= addr_reg[13:0];
          state <= (cmd_reg == CMD_READ) ? MDC_WAIT : MDC_DONE;
        end
        MDC_WAIT: if (LINK.dq_valid && !seen) begin
          rdata <= LINK.dq_from_dev;  // R17
          seen <= 1'b1;
          state <= MDC_DONE;
        end
        MDC_DONE: state <= MDC_IDLE;
        default:  state <= MDC_IDLE;
      endcase
    end
  end
endmodule  // mddrc_ctrl
`default_nettype wire

// File: sim/mddrc_chk.sv
// link checker: read latency, burst walk and status word
// assumes plain interface signals on the shared core clock
`timescale 1ns/1ps
`default_nettype none
module mddrc_chk
  import mddrc_pkg::*;
(
  // clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // link
  input wire logic [3:0]  cmd,
  input wire logic [1:0]  bank,
  input wire logic [13:0] addr,
  input wire logic [15:0] dq_from_dev,
  input wire logic        dq_valid
);
  logic [13:0] std;
  logic        armed;
  logic        stat;
  logic [3:0]  run;
  logic [3:0]  len;
  logic [3:0]  next_len;
  logic [9:0]  col;
  logic [9:0]  msk;
  logic        lat3;
  // ****************************************
  // shadow of the settings seen on the link
  // ****************************************
  assign lat3 = (std[LAT_MSB:LAT_LSB] == LAT_THREE);
  assign next_len = armed ? 4'h2 : (std[2:0] == BURST_FOUR) ? 4'h4 :
                    (std[2:0] == BURST_EIGHT) ? 4'h8 : 4'h2;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) std <= STD_RESET;
    else if (cmd == CMD_LOAD && bank == BANK_STD) std <= addr;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) armed <= 1'b0;
    else if (cmd == CMD_LOAD && bank == BANK_STATUS) armed <= 1'b1;
    else if (cmd == CMD_READ) armed <= 1'b0;
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      stat <= 1'b0;
      col  <= 10'h000;
      len  <= 4'h2;
      msk  <= 10'h001;
    end else if (cmd == CMD_READ) begin
      stat <= armed;
      col  <= addr[9:0];
      len  <= next_len;
      msk  <= {6'h00, next_len - 4'h1};
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) run <= 4'h0;
    else run <= dq_valid ? run + 4'h1 : 4'h0;
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_lat2;
    !dq_valid ##1 dq_valid;
  endsequence
  sequence s_lat3;
    !dq_valid ##1 !dq_valid ##1 dq_valid;
  endsequence
  a_lat2_first_beat: assert property (
    cmd == CMD_READ && !lat3 |-> ##1 s_lat2) else $error("latency two");
  a_lat3_first_beat: assert property (
    cmd == CMD_READ && lat3 |-> ##1 s_lat3) else $error("latency three");
  a_burst_len: assert property ($fell(dq_valid) |-> run == len)
    else $error("burst length");
  a_first_col: assert property (
    $rose(dq_valid) && !stat |-> dq_from_dev[9:0] == col)
    else $error("start column");
  a_in_block: assert property (
    dq_valid && !stat |-> (dq_from_dev[9:0] & ~msk) == (col & ~msk))
    else $error("left block");
  a_seq_step: assert property (
    dq_valid && $past(dq_valid) && !stat && !std[3] |->
    ((dq_from_dev ^ ($past(dq_from_dev) + 16'h1)) & {6'h00, msk}) == 0)
    else $error("sequential step");
  a_status_fields: assert property ($rose(dq_valid) && stat |->
    dq_from_dev[7:0] == {STAT_REV, STAT_MAKER} &&
    dq_from_dev[15:11] == {STAT_DENS, STAT_TYPE, STAT_WIDTH})
    else $error("status fields");
  a_start_cause: assert property ($rose(dq_valid) |->
    $past(cmd, 2) == CMD_READ || $past(cmd, 3) == CMD_READ)
    else $error("data without read");
  a_ext_high_zero: assert property (
    cmd == CMD_LOAD && bank == BANK_EXT |-> addr[13:7] == 7'h00)
    else $error("ext high bits");
  a_status_load_zero: assert property (
    cmd == CMD_LOAD && bank == BANK_STATUS |-> addr[12:0] == 13'h0000)
    else $error("status load bits");
endmodule // mddrc_chk
`default_nettype wire

// File: sim/tb_top.sv
// bench: both ends joined, controller driven over ahb-lite
// assumes 25 MHz core clock and active-high reset
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mddrc_pkg::*;
;
  typedef struct packed {
    logic [2:0] burst;
    logic [2:0] lat;
    logic       inter;
    logic [9:0] col;
  } mddrc_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [1:0] htrans = 2'h0;
  logic hreadyout;
  logic [3:0] temp_level = 4'h0;
  logic self_refresh = 1'b0;
  logic deep_power_down = 1'b0;
  logic [2:0] refresh_rate;
  logic [2:0] drive_strength;
  logic [3:0] refresh_banks;
  logic [1:0] row_msb_mask;
  logic [9:0] column;
  logic [9:0] last_col;
  logic last_wr;
  logic [9:0] n;
  logic column_valid;
  logic column_write;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int beats = 0;
  // only documented codes are loaded
  mddrc_row_t rows [5] = '{'{BURST_TWO, LAT_TWO, 1'b0, 10'h0f3},
    '{BURST_FOUR, LAT_THREE, 1'b0, 10'h1a6},
    '{BURST_EIGHT, LAT_TWO, 1'b0, 10'h3ff},
    '{BURST_EIGHT, LAT_THREE, 1'b0, 10'h005},
    '{BURST_EIGHT, LAT_TWO, 1'b1, 10'h2b5}};
  logic [2:0] pc [5] = '{REFSEL_ALL, REFSEL_TWO, REFSEL_ONE, REFSEL_EIGHTH,
                         REFSEL_SIXTEEN};
  logic [5:0] pe [5] = '{6'h3c, 6'h0c, 6'h04, 6'h06, 6'h07};
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (column_valid === 1'b1) begin
      beats++;
      last_col = column;
      last_wr = column_write;
    end
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  mddrc_if link ();
  mddrc_device mddrc_device_i (.CORE_CLK(core_clk), .RST(rst),
    .LINK(link), .TEMP_LEVEL(temp_level), .SELF_REFRESH(self_refresh),
    .DEEP_POWER_DOWN(deep_power_down), .REFRESH_RATE(refresh_rate),
    .REFRESH_BANKS(refresh_banks), .ROW_MSB_MASK(row_msb_mask),
    .DRIVE_STRENGTH(drive_strength), .COLUMN(column),
    .COLUMN_VALID(column_valid), .COLUMN_WRITE(column_write));
  mddrc_ctrl mddrc_ctrl_i (.CORE_CLK(core_clk), .RST(rst), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(), .LINK(link));
  mddrc_chk mddrc_chk_i (.CORE_CLK(core_clk), .RST(rst), .cmd(link.cmd),
    .bank(link.bank), .addr(link.addr), .dq_from_dev(link.dq_from_dev),
    .dq_valid(link.dq_valid));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata;
  endtask
  task automatic issue(input logic [1:0] b, input logic [13:0] a,
                       input logic [3:0] c);
    ahb(1'b1, REG_ADDR, {16'h0, b, a});
    ahb(1'b1, REG_CMD, {28'h0, c});
    repeat (14) @(posedge core_clk);
    ahb(1'b0, REG_STATUS, 32'h0);
    check(r, 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    ahb(1'b0, REG_STATUS, 32'h0);
    check(r, 32'h1);
    ahb(1'b0, 8'h10, 32'h0);
    check(r, 32'h0);
    foreach (rows[i]) begin
      n = 10'h1 << rows[i].burst;
      issue(BANK_STD, {7'h0, rows[i].lat, rows[i].inter,
                       rows[i].burst}, CMD_LOAD);
      beats = 0;
      issue(BANK_STD, {4'h0, rows[i].col}, CMD_READ);
      check(beats, {22'h0, n});
      check({31'h0, last_wr}, 32'h0);
      ahb(1'b0, REG_RDATA, 32'h0);
      check(r, {15'h0, 1'b1, 6'h0, rows[i].col});
      beats = 0;
      issue(BANK_STD, {4'h0, rows[i].col}, CMD_WRITE);
      check(beats, {22'h0, n});
      check({31'h0, last_wr}, 32'h1);
      check({22'h0, last_col}, {22'h0, (rows[i].col & ~(n - 10'h1)) |
            ((rows[i].inter ? rows[i].col ^ (n - 10'h1)
                            : rows[i].col + n - 10'h1) & (n - 10'h1))});
    end
    temp_level <= 4'h3;
    repeat (6) @(posedge core_clk);
    check({29'h0, refresh_rate}, 32'h3);
    issue(BANK_STATUS, 14'h0000, CMD_LOAD);
    issue(BANK_EXT, 14'h0005, CMD_READ);
    ahb(1'b0, REG_RDATA, 32'h0);
    check(r, {15'h0, 1'b1, STAT_DENS, STAT_TYPE, STAT_WIDTH, 3'h3,
              STAT_REV, STAT_MAKER});
    issue(BANK_STD, 14'h0021, CMD_READ);
    ahb(1'b0, REG_RDATA, 32'h0);
    check(r, 32'h00010021);
    temp_level <= 4'h9;
    repeat (6) @(posedge core_clk);
    check({29'h0, refresh_rate}, 32'h7);
    beats = 0;
    issue(BANK_STD, 14'h0010, CMD_DESEL);
    check(beats, 32'h0);
    self_refresh <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      issue(BANK_EXT, {7'h0, k[1:0] ^ 2'h3, 2'h0, pc[k]}, CMD_LOAD);
      check({29'h0, drive_strength}, {30'h0, k[1:0] ^ 2'h3});
      check({26'h0, refresh_banks, row_msb_mask}, {26'h0, pe[k]});
    end
    self_refresh <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({28'h0, refresh_banks}, 32'h0);
    check({29'h0, drive_strength}, 32'h3);
    deep_power_down <= 1'b1;
    repeat (2) @(posedge core_clk);
    deep_power_down <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({29'h0, drive_strength}, 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
